// >>> hdl/chain_pkg.sv
// constants and types of the chained serial readout block
package chain_pkg;
  localparam int RESULT_BITS       = 18;
  localparam int CLK_MHZ           = 100;
  localparam int CONV_TIME_NS      = 1000;
  localparam int CONV_CYCLES       = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH        = 16;
  localparam logic [17:0] RESULT_RESET = 18'h00000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_READOUT,
    ST_OTHER
  } phase_t;
endpackage

// >>> hdl/result_fifo.sv
// small fifo holding conversion results before they are loaded for shifting
`timescale 1ns/10ps
module result_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;
  logic [AW:0]      next_wr;
  logic [AW:0]      next_rd;
  logic             next_out_valid;
  logic [AW+1:0]    next_occ;

  assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  // accept only when ready was shown, so the source sees an honest handshake
  assign push  = in_valid && in_ready && !full;
  // prime the output register whenever it is free or being taken
  assign pop   = !empty && (!out_valid || out_ready);

  // occupancy after this edge counts the output register too
  assign next_wr        = wr_ptr + (AW+1)'(push);
  assign next_rd        = rd_ptr + (AW+1)'(pop);
  assign next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
  assign next_occ       = (AW+2)'(next_wr - next_rd) + (AW+2)'(next_out_valid);

  // storage written only on accepted words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // read data registered; valid held until the consumer takes it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr[AW-1:0]];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // ready registered from the next occupancy, output register included, so the source sees back-pressure cleanly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (next_occ < (AW+2)'(DEPTH));
    end
  end
endmodule // result_fifo

// >>> hdl/chain_readout.sv
// chained serial readout of an 18-bit converter with optional busy bit
`timescale 1ns/10ps
module chain_readout
  import chain_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CONVERSION_START_IN,
  input  wire logic        HOST_SERIAL_IN,
  input  wire logic        SERIAL_CLK,
  input  wire logic [17:0] SAMPLE_IN,
  input  wire logic        SAMPLE_VALID,
  output logic             SAMPLE_READY,
  output logic             SERIAL_OUT,
  output logic             SERIAL_OUT_OE_N,
  output logic             POWERED_UP,
  output logic             CONVERTING,
  output logic             BUSY_MODE,
  output logic             OTHER_MODE
);
  initial begin
    if (CONV_LEN < 1 || CONV_LEN > 65535) $error("conversion length out of range");
  end

  // two-flop synchronisers for the start, serial input and serial clock pins
  logic [1:0] cs_sync;
  logic [1:0] si_sync;
  logic [1:0] sc_sync;
  logic       cs_q;
  logic       sc_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cs_sync <= 2'h0;
      si_sync <= 2'h0;
      sc_sync <= 2'h0;
      cs_q    <= 1'b0;
      sc_q    <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], CONVERSION_START_IN};
      si_sync <= {si_sync[0], HOST_SERIAL_IN};
      sc_sync <= {sc_sync[0], SERIAL_CLK};
      cs_q    <= cs_sync[1];
      sc_q    <= sc_sync[1];
    end
  end

  logic cs;
  logic si;
  logic sc;
  logic start_rise;
  logic sclk_fall;

  assign cs         = cs_sync[1];
  assign si         = si_sync[1];
  assign sc         = sc_sync[1];
  assign start_rise = cs && !cs_q;
  assign sclk_fall  = !sc && sc_q;

  // fifo in front of the shift register; analog side pushes samples
  logic        fifo_valid;
  logic [17:0] fifo_data;
  logic        fifo_take;

  result_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .nrst      (NRST),
    .in_valid  (SAMPLE_VALID),
    .in_ready  (SAMPLE_READY),
    .in_data   (SAMPLE_IN),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  phase_t      phase;
  logic [15:0] conv_cnt;
  logic        busy_sel;
  logic [17:0] held;
  logic        conv_done;

  assign conv_done = (phase == ST_CONVERT) && (conv_cnt == 16'(CONV_LEN - 1));
  // sample taken at start edge; oldest queued word stands for the captured input
  assign fifo_take = start_rise && !si && fifo_valid;

  // captured sample kept until the next fifo_take
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      held <= RESULT_RESET;
    end else if (fifo_take) begin
      held <= fifo_data;
    end
  end

  // mode select and conversion sequencing on the internal clock
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      phase    <= ST_IDLE;
      conv_cnt <= 16'h0000;
      busy_sel <= 1'b0;
    end else begin
      unique case (phase)
        ST_IDLE, ST_READOUT, ST_OTHER: begin
          if (start_rise) begin
            conv_cnt <= 16'h0000;
            busy_sel <= sc;
            // low input chains; high input leaves to the other mode
            phase    <= si ? ST_OTHER : ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          // serial clock is ignored here; length is fixed by the counter
          conv_cnt <= conv_cnt + 16'h0001;
          if (conv_done) begin
            phase <= ST_READOUT;
          end
        end
      endcase
    end
  end

  // shift register plus the bit currently on the pin
  logic [17:0] shreg;
  logic        out_bit;
  logic        first_fall;

  // the first fall of a busy frame only moves the msb out; the upstream
  // busy bit seen on the input then is not captured
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      shreg      <= RESULT_RESET;
      out_bit    <= 1'b0;
      first_fall <= 1'b0;
    end else if (conv_done) begin
      shreg      <= held;
      first_fall <= busy_sel;
      if (busy_sel) begin
        out_bit <= 1'b1;
      end else begin
        out_bit <= held[17];
      end
    end else if (phase == ST_READOUT && sclk_fall) begin
      first_fall <= 1'b0;
      if (first_fall) begin
        out_bit <= shreg[17];
      end else begin
        out_bit <= shreg[16];
        shreg   <= {shreg[16:0], si};
      end
    end
  end

  // pin drive; the bit moves after a falling clock edge or when a result is loaded at conversion end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b1;
    end else if (!si && !cs) begin
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b0;
    end else if (phase == ST_OTHER) begin
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b1;
    end else begin
      SERIAL_OUT      <= out_bit;
      SERIAL_OUT_OE_N <= 1'b0;
    end
  end

  // status flags; power is up only while converting
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      POWERED_UP <= 1'b0;
      CONVERTING <= 1'b0;
      BUSY_MODE  <= 1'b0;
      OTHER_MODE <= 1'b0;
    end else begin
      POWERED_UP <= (phase == ST_CONVERT);
      CONVERTING <= (phase == ST_CONVERT);
      BUSY_MODE  <= busy_sel;
      OTHER_MODE <= (phase == ST_OTHER);
    end
  end
endmodule // chain_readout

// >>> test/chain_readout_props.sv
// assertions on the chained readout ports
`timescale 1ns/10ps
module chain_readout_props #(
  parameter int CONV_LEN = 10
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CONVERSION_START_IN,
  input wire logic HOST_SERIAL_IN,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE_N,
  input wire logic POWERED_UP,
  input wire logic CONVERTING,
  input wire logic BUSY_MODE,
  input wire logic OTHER_MODE
);
  logic [7:0] cnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // length of the converting phase, judged at its fall
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) cnt <= 8'h00;
    else if (CONVERTING) cnt <= cnt + 8'h01;
    else cnt <= 8'h00;
  end
  property p_low;
    (!HOST_SERIAL_IN && !CONVERSION_START_IN)[*5] |-> !SERIAL_OUT && !SERIAL_OUT_OE_N;
  endproperty
  a_low: assert property (p_low) else $error("output not held low");
  property p_pwr;
    POWERED_UP == CONVERTING;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power not tied to conversion");
  property p_len;
    $fell(CONVERTING) |-> int'(cnt) == CONV_LEN;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_oth;
    OTHER_MODE && HOST_SERIAL_IN[*4] |-> SERIAL_OUT_OE_N;
  endproperty
  a_oth: assert property (p_oth) else $error("output driven in other mode");
  property p_bsy;
    BUSY_MODE && $fell(CONVERTING) |-> ##[0:2] SERIAL_OUT;
  endproperty
  a_bsy: assert property (p_bsy) else $error("busy bit missing");
  property p_mode;
    CONVERTING && $past(CONVERTING) |-> $stable(BUSY_MODE);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved in conversion");
  // a high serial clock must not move the output once readout runs
  property p_hold;
    (SERIAL_CLK && CONVERSION_START_IN && !CONVERTING)[*8] |-> $stable(SERIAL_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved on high clock");
  property p_conv;
    CONVERTING[*4] |-> $stable(SERIAL_OUT);
  endproperty
  a_conv: assert property (p_conv) else $error("output moved in conversion");
  c_plain: cover property ($fell(CONVERTING) && !BUSY_MODE);
  c_busy: cover property ($fell(CONVERTING) && BUSY_MODE);
  c_other: cover property ($rose(OTHER_MODE));
endmodule // chain_readout_props

// >>> test/host_model.sv
// host model: drives start and serial clock, collects the chain stream
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        busy,
  input  wire logic [5:0]  nfall,
  input  wire logic        sdo,
  output logic             sclk,
  output logic             start,
  output logic [36:0]      rx,
  output logic             done
);
  // one frame per go; the clock stands low between frames
  initial begin
    sclk = 0;
    start = 0;
    rx = '0;
    done = 0;
    forever begin
      @(posedge go);
      @(posedge clk) #1;
      done = 0;
      sclk = busy;
      #80 start = 1;
      #400;
      for (int i = 0; i < nfall; i++) begin
        sclk = 1;
        #80 rx = {rx[35:0], sdo};
        sclk = 0;
        #80;
      end
      start = 0;
      #80 done = 1;
    end
  end
endmodule // host_model

// >>> test/tb.sv
// bench for the chained readout: fifo fill, plain and busy chains, other mode
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb;
  localparam logic [17:0] UPW = 18'h2c3a1;
  logic clk = 0, nrst = 0, go = 0, busy_sel = 0, din_hi = 0, valid = 0;
  logic start, sclk, hsi, ready, sdo, oe_n, pwr, conv, busy_m, other_m, done;
  logic [17:0] sample = '0;
  logic [18:0] up = '0;
  logic [5:0]  nfall = '0;
  logic [36:0] h_rx;
  int fails = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  // upstream device of the chain, shifting on each serial clock fall
  always @(posedge conv) #1 up = busy_sel ? {1'b1, UPW} : {UPW, 1'b0};
  always @(negedge sclk) #20 up = up << 1;
  assign hsi = up[18] | din_hi;
  chain_readout #(.CONV_LEN(10)) u_dut (.CLK(clk), .NRST(nrst),
    .CONVERSION_START_IN(start), .HOST_SERIAL_IN(hsi), .SERIAL_CLK(sclk),
    .SAMPLE_IN(sample), .SAMPLE_VALID(valid), .SAMPLE_READY(ready), .SERIAL_OUT(sdo),
    .SERIAL_OUT_OE_N(oe_n), .POWERED_UP(pwr), .CONVERTING(conv), .BUSY_MODE(busy_m),
    .OTHER_MODE(other_m));
  host_model u_host (.clk(clk), .go(go), .busy(busy_sel), .nfall(nfall), .sdo(sdo),
    .sclk(sclk), .start(start), .rx(h_rx), .done(done));
  function automatic logic [17:0] wd(int i);
    return 18'h2d2d3 ^ 18'(i * 9127);
  endfunction
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task run(input logic b, input logic [5:0] nf);
    busy_sel = b;
    nfall = nf;
    go = 1;
    @(posedge clk) #1 go = 0;
    @(posedge done);
    @(posedge clk) #1;
  endtask
  // valid stays up; a word moves on only at an edge that saw ready
  task t_fill;
    int n;
    n = 0;
    valid = 1;
    for (int k = 0; k < 24; k++) begin
      sample = wd(n);
      @(posedge clk);
      if (ready === 1'b1) n++;
      #1;
    end
    valid = 0;
    `CHK("fill count", 16, n)
    $display("test fill done");
  endtask
  task t_plain;
    for (int i = 0; i < 16; i++) begin
      run(0, 36);
      `CHK("plain stream", {wd(i), UPW}, h_rx[35:0])
      `CHK("plain mode", 1'b0, busy_m)
    end
    $display("test plain done");
  endtask
  task t_other;
    din_hi = 1;
    run(0, 0);
    `CHK("other mode", 1'b1, other_m)
    `CHK("other oe", 1'b1, oe_n)
    din_hi = 0;
    up = '0;
    $display("test other done");
  endtask
  // fifo now empty: the held word comes back
  task t_busy;
    run(1, 37);
    `CHK("busy stream", {1'b1, wd(15), UPW}, h_rx)
    `CHK("busy mode", 1'b1, busy_m)
    $display("test busy done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1;
    repeat (4) @(posedge clk);
    #1;
    t_fill;
    t_plain;
    t_other;
    t_busy;
    final_report;
  end
endmodule // tb
bind chain_readout chain_readout_props #(.CONV_LEN(CONV_LEN)) u_props (.CLK(CLK),
  .NRST(NRST), .CONVERSION_START_IN(CONVERSION_START_IN), .HOST_SERIAL_IN(HOST_SERIAL_IN),
  .SERIAL_CLK(SERIAL_CLK), .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
  .POWERED_UP(POWERED_UP), .CONVERTING(CONVERTING), .BUSY_MODE(BUSY_MODE),
  .OTHER_MODE(OTHER_MODE));
